//--- rfa_pkg.sv
package rfa_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and bus widths.
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CFG = 8'h00;     // Configuration word.
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;  // Live state and short flag.
  localparam logic [31:0] CFG_RESET = 32'h0000_0000; // Front end powered down.

  // ----------------------------------------------------------------
  // Configuration word bit positions.
  // ----------------------------------------------------------------
  localparam int CB_PWR = 0;
  localparam int CB_MOD_LO = 1;
  localparam int CB_SHORT = 4;
  localparam int CB_PAR = 5;
  localparam int CB_PP = 6;
  localparam int CB_HPF_LO = 7;
  localparam int CB_LPF = 9;
  localparam int CB_GAIN_LO = 10;
  localparam int CB_RXSEL = 13;
  localparam int CB_AGC = 14;
  localparam int CB_SKIP = 15;
  localparam int CB_SLOW = 16;
  localparam int CB_ATK_LO = 17;
  localparam int CB_WAIT_LO = 19;
  localparam int CB_LONG = 24;
  localparam logic [2:0] MOD_OOK = 3'h1;  // Bits 1..3 = 1,0,0 select OOK.

  // ----------------------------------------------------------------
  // Status word bit positions.
  // ----------------------------------------------------------------
  localparam int SB_GAIN_LO = 0;
  localparam int SB_AGC_LO = 3;
  localparam int SB_MOD_LO = 5;
  localparam int SB_SHORT_NOW = 7;
  localparam int SB_SHORT_STICKY = 8;

  // ----------------------------------------------------------------
  // Timing, as times in ns and derived cycle counts at the clock rate.
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int PRE_HOLD_NS = 1000;
  localparam int POST_HOLD_NS = 5000;
  localparam int POST_LONG_NS = 10000;
  localparam int ATK_NS0 = 50;
  localparam int ATK_NS1 = 100;
  localparam int ATK_NS2 = 200;
  localparam int ATK_NS3 = 400;
  localparam int WAIT_NS0 = 2000;
  localparam int WAIT_NS1 = 4000;
  localparam int WAIT_NS2 = 8000;
  localparam int WAIT_NS3 = 16000;
  localparam int TM_W = 12;
  // Least times round up to whole cycles.
  localparam logic [TM_W-1:0] PRE_HOLD_CYC = TM_W'((PRE_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TM_W-1:0] POST_HOLD_CYC = TM_W'((POST_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [TM_W-1:0] POST_LONG_CYC = TM_W'((POST_LONG_NS * CLK_MHZ + 999) / 1000);

  // Cycles per attack step for the two-bit attack field.
  function automatic logic [TM_W-1:0] atk_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: atk_cycles = TM_W'((ATK_NS0 * CLK_MHZ + 999) / 1000);
      2'h1: atk_cycles = TM_W'((ATK_NS1 * CLK_MHZ + 999) / 1000);
      2'h2: atk_cycles = TM_W'((ATK_NS2 * CLK_MHZ + 999) / 1000);
      default: atk_cycles = TM_W'((ATK_NS3 * CLK_MHZ + 999) / 1000);
    endcase
  endfunction

  // Cycles of the decay wait time for the two-bit wait field.
  function automatic logic [TM_W-1:0] wait_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: wait_cycles = TM_W'((WAIT_NS0 * CLK_MHZ + 999) / 1000);
      2'h1: wait_cycles = TM_W'((WAIT_NS1 * CLK_MHZ + 999) / 1000);
      2'h2: wait_cycles = TM_W'((WAIT_NS2 * CLK_MHZ + 999) / 1000);
      default: wait_cycles = TM_W'((WAIT_NS3 * CLK_MHZ + 999) / 1000);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State machines, Gray coded along the usual path.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MOD_IDLE = 2'h0,
    MOD_PRE = 2'h1,
    MOD_ACTIVE = 2'h3,
    MOD_POST = 2'h2
  } rfa_mod_st_t;

  typedef enum logic [1:0] {
    AGC_MAX = 2'h0,
    AGC_ATTACK = 2'h1,
    AGC_HOLD = 2'h3,
    AGC_DECAY = 2'h2
  } rfa_agc_st_t;

  // Control bundle towards the analog front end.
  typedef struct packed {
    logic afe_pwr;        // Front end powered.
    logic field_on;       // Carrier present on the antenna outputs.
    logic field_low;      // Carrier lowered for ASK.
    logic [2:0] ask_depth; // ASK depth code, 7% to 30% index.
    logic drv_a_en;       // Driver on antenna_output_a enabled.
    logic drv_b_en;       // Driver on antenna_output_b enabled.
    logic push_pull;      // Drivers in push-pull.
    logic rx_hold;        // Receiver input disconnected.
    logic rx_sel;         // 1: rf_input_secondary, 0: rf_input_primary.
    logic [1:0] hpf_sel;  // Highpass corner select.
    logic lpf_sel;        // Lowpass corner select.
    logic [2:0] gain;     // Receiver gain step.
  } rfa_afe_t;

endpackage

//--- rfa_front_end.sv
`timescale 1ns/100ps
module rfa_front_end (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [rfa_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_mod_req,
  input wire logic i_rf_input_primary_attack,
  input wire logic i_rf_input_primary_decay,
  input wire logic i_rf_input_secondary_attack,
  input wire logic i_rf_input_secondary_decay,
  input wire logic i_antenna_output_a_short,
  input wire logic i_antenna_output_b_short,
  output rfa_pkg::rfa_afe_t o_afe
);
  import rfa_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_in; // Asynchronous pins, gathered.
  logic [NSYNC-1:0] sync1_q; // First stage, read only by the second.
  logic [NSYNC-1:0] sync2_q; // Safe for logic.
  assign raw_in = {i_antenna_output_b_short, i_antenna_output_a_short,
                   i_rf_input_secondary_decay, i_rf_input_secondary_attack,
                   i_rf_input_primary_decay, i_rf_input_primary_attack, i_mod_req};

  // Two flops per pin; every analog comparator and the modulation request arrive unclocked.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Configuration decode.
  // ----------------------------------------------------------------
  logic [31:0] cfg_q; // Configuration word.
  logic [31:0] cfg_d;
  logic pwr; // Front end powered.
  logic agc_on; // AGC active.
  logic is_ook; // OOK selected.
  logic [2:0] gain_max; // Gain field.
  logic atk_lvl; // Selected input above attack threshold.
  logic dec_lvl; // Selected input above decay threshold.
  logic short_now; // A short is seen on either output.
  logic [TM_W-1:0] atk_cyc; // Cycles per attack step.
  logic [TM_W-1:0] wait_cyc; // Decay wait time in cycles.
  logic [TM_W-1:0] post_cyc; // Post-modulation hold in cycles.

  assign pwr = cfg_q[CB_PWR];
  assign agc_on = pwr && cfg_q[CB_AGC];
  assign is_ook = (cfg_q[CB_MOD_LO +: 3] == MOD_OOK);
  assign gain_max = cfg_q[CB_GAIN_LO +: 3];
  // The receive envelope comes from the input chosen by the select bit.
  assign atk_lvl = cfg_q[CB_RXSEL] ? sync2_q[3] : sync2_q[1];
  assign dec_lvl = cfg_q[CB_RXSEL] ? sync2_q[4] : sync2_q[2];
  assign short_now = sync2_q[5] | sync2_q[6];
  assign atk_cyc = atk_cycles(cfg_q[CB_ATK_LO +: 2]);
  assign wait_cyc = wait_cycles(cfg_q[CB_WAIT_LO +: 2]);
  assign post_cyc = cfg_q[CB_LONG] ? POST_LONG_CYC : POST_HOLD_CYC;

  // ----------------------------------------------------------------
  // APB slave: one wait state so that read data comes from a flop.
  // ----------------------------------------------------------------
  logic sticky_q; // Short seen since last clear.
  logic sticky_d;
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;
  logic wr_now; // Write completes at this edge.
  logic [31:0] wmask; // Byte-lane mask from the strobes.
  logic [31:0] status; // Status word as read.
  rfa_mod_st_t mod_st_q;
  rfa_mod_st_t mod_st_d;
  rfa_agc_st_t agc_st_q;
  rfa_agc_st_t agc_st_d;
  logic [2:0] gain_q;
  logic [2:0] gain_d;

  // Each strobe opens one byte lane of the write data.
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{i_pstrb[b]}};
  end

  assign wr_now = i_psel && i_penable && o_pready && i_pwrite;
  always_comb begin
    status = '0;
    status[SB_GAIN_LO +: 3] = gain_q;
    status[SB_AGC_LO +: 2] = agc_st_q;
    status[SB_MOD_LO +: 2] = mod_st_q;
    status[SB_SHORT_NOW] = short_now;
    status[SB_SHORT_STICKY] = sticky_q;
  end

  // Bus handshake, configuration writes and the sticky short flag.
  always_comb begin
    cfg_d = cfg_q;
    sticky_d = sticky_q;
    prdata_d = '0;
    pslverr_d = 1'b0;
    pready_d = 1'b0;
    if (i_psel && i_penable && !o_pready) begin
      // First access cycle: prepare the answer for the next edge.
      pready_d = 1'b1;
      if (i_paddr == REG_CFG) begin
        prdata_d = cfg_q;
      end else if (i_paddr == REG_STATUS) begin
        prdata_d = status;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    // The word stands until software writes it again.
    if (wr_now && i_paddr == REG_CFG) begin
      cfg_d = (cfg_q & ~wmask) | (i_pwdata & wmask);
    end
    if (wr_now && i_paddr == REG_STATUS && i_pstrb[1] && i_pwdata[SB_SHORT_STICKY]) begin
      sticky_d = 1'b0;
    end
    // A short seen in the clearing cycle is kept: set wins.
    if (short_now) begin
      sticky_d = 1'b1;
    end
  end

  // Registers of the bus slave.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_q <= CFG_RESET;
      sticky_q <= 1'b0;
      o_prdata <= '0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      sticky_q <= sticky_d;
      o_prdata <= prdata_d;
      o_pready <= pready_d;
      o_pslverr <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Modulation sequencer with receiver hold window.
  // ----------------------------------------------------------------
  logic [TM_W-1:0] mod_tm_q;
  logic [TM_W-1:0] mod_tm_d;

  // Receiver is disconnected before the pulse, during it and after it.
  always_comb begin
    mod_st_d = mod_st_q;
    mod_tm_d = '0;
    if (!pwr) begin
      mod_st_d = MOD_IDLE;
    end else begin
      case (mod_st_q)
        MOD_IDLE: begin
          if (sync2_q[0]) begin
            mod_st_d = MOD_PRE;
          end
        end
        MOD_PRE: begin
          // Pre-hold always runs its full length so the DC point is frozen first.
          if (mod_tm_q == PRE_HOLD_CYC - 1'b1) begin
            mod_st_d = sync2_q[0] ? MOD_ACTIVE : MOD_POST;
          end else begin
            mod_tm_d = mod_tm_q + 1'b1;
          end
        end
        MOD_ACTIVE: begin
          if (!sync2_q[0]) begin
            mod_st_d = MOD_POST;
          end
        end
        MOD_POST: begin
          if (mod_tm_q == post_cyc - 1'b1) begin
            mod_st_d = MOD_IDLE;
          end else begin
            mod_tm_d = mod_tm_q + 1'b1;
          end
        end
        default: mod_st_d = MOD_IDLE;
      endcase
    end
  end

  // Registers of the modulation sequencer.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mod_st_q <= MOD_IDLE;
      mod_tm_q <= '0;
    end else begin
      mod_st_q <= mod_st_d;
      mod_tm_q <= mod_tm_d;
    end
  end

  // ----------------------------------------------------------------
  // Automatic gain control.
  // ----------------------------------------------------------------
  logic [TM_W-1:0] agc_tm_q; // Attack step or decay wait timer.
  logic [TM_W-1:0] agc_tm_d;
  logic burst_new_q; // Next pulse opens a new burst.
  logic burst_new_d;
  logic skip_q; // Currently letting a first pulse through.
  logic skip_d;

  // Gain steps down on attack, holds, then returns fast or slowly.
  always_comb begin
    agc_st_d = agc_st_q;
    agc_tm_d = '0;
    gain_d = gain_q;
    burst_new_d = burst_new_q;
    skip_d = skip_q;
    if (!agc_on) begin
      agc_st_d = AGC_MAX;
      gain_d = gain_max;
      burst_new_d = 1'b1;
      skip_d = 1'b0;
    end else begin
      case (agc_st_q)
        AGC_MAX: begin
          gain_d = gain_max;
          // Quiet for one wait time means the next pulse opens a burst.
          if (!dec_lvl && !skip_q) begin
            if (agc_tm_q == wait_cyc - 1'b1) begin
              burst_new_d = 1'b1;
            end else begin
              agc_tm_d = agc_tm_q + 1'b1;
            end
          end
          if (skip_q) begin
            // The skipped pulse ends when the level falls under decay.
            if (!dec_lvl) begin
              skip_d = 1'b0;
              burst_new_d = 1'b0;
            end
          end else if (atk_lvl) begin
            if (cfg_q[CB_SKIP] && burst_new_q) begin
              skip_d = 1'b1;
            end else begin
              agc_st_d = AGC_ATTACK;
              burst_new_d = 1'b0;
            end
          end
        end
        AGC_ATTACK: begin
          if (!atk_lvl) begin
            agc_st_d = AGC_HOLD;
          end else if (agc_tm_q == atk_cyc - 1'b1) begin
            if (gain_q != 3'h0) begin
              gain_d = gain_q - 1'b1;
            end
          end else begin
            agc_tm_d = agc_tm_q + 1'b1;
          end
        end
        AGC_HOLD: begin
          if (atk_lvl) begin
            agc_st_d = AGC_ATTACK;
          end else if (!dec_lvl && cfg_q[CB_SLOW]) begin
            // Slow decay starts at once; each step then waits a full period.
            agc_st_d = AGC_DECAY;
          end else if (!dec_lvl) begin
            // Gain only moves after a full wait time below decay.
            if (agc_tm_q == wait_cyc - 1'b1) begin
              agc_st_d = AGC_MAX;
              gain_d = gain_max;
              burst_new_d = 1'b1;
            end else begin
              agc_tm_d = agc_tm_q + 1'b1;
            end
          end
          // Above decay the gain stays put and the timer restarts.
        end
        AGC_DECAY: begin
          if (atk_lvl) begin
            agc_st_d = AGC_ATTACK;
          end else if (dec_lvl) begin
            agc_st_d = AGC_HOLD;
          end else if (gain_q >= gain_max) begin
            agc_st_d = AGC_MAX;
            gain_d = gain_max;
            burst_new_d = 1'b1;
          end else if (agc_tm_q == wait_cyc - 1'b1) begin
            gain_d = gain_q + 1'b1;
          end else begin
            agc_tm_d = agc_tm_q + 1'b1;
          end
        end
        default: agc_st_d = AGC_MAX;
      endcase
    end
  end

  // Registers of the gain control.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      agc_st_q <= AGC_MAX;
      agc_tm_q <= '0;
      gain_q <= 3'h0;
      burst_new_q <= 1'b1;
      skip_q <= 1'b0;
    end else begin
      agc_st_q <= agc_st_d;
      agc_tm_q <= agc_tm_d;
      gain_q <= gain_d;
      burst_new_q <= burst_new_d;
      skip_q <= skip_d;
    end
  end

  // ----------------------------------------------------------------
  // Front-end control outputs.
  // ----------------------------------------------------------------
  rfa_afe_t afe_d;

  // Drivers drop at once on a short; the analog side must tolerate two sync cycles and the output register.
  always_comb begin
    afe_d = '0;
    if (pwr) begin
      afe_d.afe_pwr = 1'b1;
      afe_d.field_on = !(mod_st_q == MOD_ACTIVE && is_ook);
      afe_d.field_low = (mod_st_q == MOD_ACTIVE) && !is_ook;
      afe_d.ask_depth = cfg_q[CB_MOD_LO +: 3];
      afe_d.push_pull = cfg_q[CB_PP];
      afe_d.drv_a_en = 1'b1;
      afe_d.drv_b_en = cfg_q[CB_PAR] || cfg_q[CB_PP];
      if (cfg_q[CB_SHORT] && short_now) begin
        afe_d.drv_a_en = 1'b0;
        afe_d.drv_b_en = 1'b0;
      end
      afe_d.rx_hold = (mod_st_q != MOD_IDLE);
      afe_d.rx_sel = cfg_q[CB_RXSEL];
      afe_d.hpf_sel = cfg_q[CB_HPF_LO +: 2];
      afe_d.lpf_sel = cfg_q[CB_LPF];
      afe_d.gain = gain_q;
    end
  end

  // Output register.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_afe <= '0;
    end else begin
      o_afe <= afe_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and cover points.
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  short_drv_off_a: assert property (pwr && cfg_q[CB_SHORT] && short_now |=>
    !o_afe.drv_a_en && !o_afe.drv_b_en) else $error("drivers on during short");
  ook_stop_a: assert property (pwr && is_ook && mod_st_q == MOD_ACTIVE |=>
    !o_afe.field_on) else $error("field not stopped in OOK");
  ask_low_a: assert property (pwr && !is_ook && mod_st_q == MOD_ACTIVE |=>
    o_afe.field_on && o_afe.field_low) else $error("field not lowered in ASK");
  rx_hold_a: assert property (pwr && sync2_q[0] && mod_st_q == MOD_IDLE |=>
    ##1 o_afe.rx_hold [*8]) else $error("receiver not held at pulse start");
  post_hold_a: assert property (mod_st_q == MOD_POST |-> mod_tm_q < post_cyc)
    else $error("post hold overran");
  post_end_a: assert property (pwr && mod_st_q == MOD_POST && mod_tm_q == post_cyc - 1'b1
    |=> mod_st_q == MOD_IDLE ##1 !o_afe.rx_hold) else $error("post hold did not end");
  rx_route_a: assert property (pwr |=> o_afe.rx_sel == $past(cfg_q[CB_RXSEL]) &&
    o_afe.hpf_sel == $past(cfg_q[CB_HPF_LO +: 2])) else $error("receiver routing wrong");
  manual_gain_a: assert property (!cfg_q[CB_AGC] |=> gain_q == $past(gain_max))
    else $error("manual gain not applied");
  agc_max_a: assert property (agc_on && agc_st_q == AGC_MAX && $stable(cfg_q)
    |-> gain_q == gain_max) else $error("gain not at maximum");
  attack_step_a: assert property (agc_on && agc_st_q == AGC_ATTACK && atk_lvl &&
    agc_tm_q == atk_cyc - 1'b1 && gain_q != 3'h0 |=> gain_q == $past(gain_q) - 1'b1)
    else $error("attack step missing");
  hold_keep_a: assert property (agc_on && agc_st_q == AGC_HOLD && dec_lvl && !atk_lvl
    |=> gain_q == $past(gain_q)) else $error("gain moved in hold");
  pwr_off_a: assert property (!pwr |=> o_afe == '0) else $error("front end not off");

  ook_pulse_c: cover property (is_ook && mod_st_q == MOD_PRE ##[1:300] mod_st_q == MOD_POST);
  attack_c: cover property (agc_st_q == AGC_ATTACK ##1 agc_st_q == AGC_HOLD);
  fast_ret_c: cover property (agc_st_q == AGC_HOLD ##1 agc_st_q == AGC_MAX);
  skip_c: cover property ($rose(skip_q));

endmodule

//--- rfa_tag_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Tag across the field, seen as receive comparator levels.
// ------------------------------------------------------------
module rfa_tag_model (
  input wire logic i_clk,
  input wire logic [1:0] i_level,
  output logic o_pri_att,
  output logic o_pri_dec,
  output logic o_sec_att,
  output logic o_sec_dec
);
  // Level 2 is above attack, 1 above decay only, 0 quiet.
  // The unused input keeps changing, so a wrong input select shows up.
  initial begin
    o_pri_att = 1'b0;
    o_pri_dec = 1'b0;
    o_sec_att = 1'b0;
    o_sec_dec = 1'b1;
  end
  always @(posedge i_clk) begin
    o_pri_att <= (i_level == 2'h2);
    o_pri_dec <= (i_level != 2'h0);
    o_sec_att <= ~o_sec_att;
    o_sec_dec <= ~o_sec_dec;
  end
endmodule

//--- rfa_front_end_test.sv
`timescale 1ns/100ps
module rfa_front_end_test;
  import rfa_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, observed outputs and counters.
  // ------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] prdata;
  logic err;
  logic pready;
  logic pslverr;
  logic mod_req = 1'b0;
  logic sh_a = 1'b0;
  logic sh_b = 1'b0;
  logic [1:0] level = 2'h0;
  logic pa;
  logic pd;
  logic sa;
  logic sd;
  rfa_afe_t afe;
  int n_errors = 0;
  int tests_run = 0;
  initial forever #2.5 i_clk = ~i_clk;
  rfa_tag_model tag (.i_clk(i_clk), .i_level(level), .o_pri_att(pa), .o_pri_dec(pd),
    .o_sec_att(sa), .o_sec_dec(sd));
  rfa_front_end dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_mod_req(mod_req),
    .i_rf_input_primary_attack(pa), .i_rf_input_primary_decay(pd),
    .i_rf_input_secondary_attack(sa), .i_rf_input_secondary_decay(sd),
    .i_antenna_output_a_short(sh_a), .i_antenna_output_b_short(sh_b), .o_afe(afe));
  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // One modulation pulse; post is the expected post hold in cycles.
  task automatic mod(input logic [31:0] cfg, input int post);
    apb(1'b1, REG_CFG, cfg);
    mod_req <= 1'b1;
    cyc(210);
    chk(32'(afe.rx_hold), 32'h1);
    chk(32'({afe.field_on, afe.field_low}), (cfg[3:1] == MOD_OOK) ? 32'h0 : 32'h3);
    mod_req <= 1'b0;
    cyc(10);
    chk(32'({afe.rx_hold, afe.field_on, afe.field_low}), 32'h6);
    cyc(post - 20);
    chk(32'(afe.rx_hold), 32'h1);
    cyc(35);
    chk(32'(afe.rx_hold), 32'h0);
  endtask
  // Front end outputs expected from a word with AGC off and no pulse.
  function automatic rfa_afe_t exp_afe(input logic [31:0] c);
    rfa_afe_t e;
    e = '0;
    e.afe_pwr = c[0];
    e.field_on = c[0];
    e.ask_depth = c[3:1];
    e.drv_a_en = c[0];
    e.drv_b_en = c[0] & (c[5] | c[6]);
    e.push_pull = c[6];
    e.rx_sel = c[13];
    e.hpf_sel = c[8:7];
    e.lpf_sel = c[9];
    e.gain = c[12:10];
    return e;
  endfunction
  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  initial begin
    logic [2:0] i;
    logic [31:0] c;
    cyc(8);
    i_rst <= 1'b0;
    cyc(1);
    chk(32'(afe), 32'h0);
    apb(1'b0, REG_CFG, 32'h0);
    chk(rd, CFG_RESET);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("reset and map test done");
    // Every modulation code except OOK (code 1), with a spread of the other fields.
    for (int k = 0; k < 8; k++) begin
      i = 3'(k);
      c = {18'h0, i[2], i, i[0], i[1:0], i[1], i[0], 1'b0, i, 1'b1};
      if (k != 1) begin
        apb(1'b1, REG_CFG, c);
        apb(1'b0, REG_CFG, 32'h0);
        chk(rd, c);
        chk(32'(afe), 32'(exp_afe(c)));
      end
    end
    apb(1'b1, REG_CFG, 32'h0000_1c6e);
    cyc(2);
    chk(32'({afe.afe_pwr, afe.field_on, afe.drv_a_en}), 32'h0);
    $display("static field test done");
    mod(32'h0000_0003, 1000);
    mod(32'h0100_000b, 2000);
    $display("modulation test done");
    sh_b <= 1'b1;
    apb(1'b1, REG_CFG, 32'h0000_0001);
    cyc(6);
    chk(32'(afe.drv_a_en), 32'h1);
    apb(1'b1, REG_CFG, 32'h0000_0031);
    cyc(6);
    chk(32'({afe.drv_a_en, afe.drv_b_en}), 32'h0);
    sh_b <= 1'b0;
    cyc(6);
    chk(32'({afe.drv_a_en, afe.drv_b_en}), 32'h3);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h1);
    apb(1'b1, REG_STATUS, 32'h0000_0100);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(32'(rd[8]), 32'h0);
    $display("short test done");
    apb(1'b1, REG_CFG, 32'h0000_5c01);
    cyc(20);
    chk(32'(afe.gain), 32'h7);
    level <= 2'h2;
    cyc(100);
    chk(32'(afe.gain), 32'h0);
    level <= 2'h1;
    cyc(600);
    chk(32'(afe.gain), 32'h0);
    level <= 2'h0;
    cyc(300);
    chk(32'(afe.gain), 32'h0);
    cyc(300);
    chk(32'(afe.gain), 32'h7);
    apb(1'b1, REG_CFG, 32'h0000_dc01);
    level <= 2'h2;
    cyc(100);
    chk(32'(afe.gain), 32'h7);
    level <= 2'h0;
    cyc(50);
    level <= 2'h2;
    cyc(100);
    chk(32'(afe.gain), 32'h0);
    apb(1'b1, REG_CFG, 32'h0001_5c01);
    level <= 2'h0;
    cyc(600);
    chk(32'(afe.gain), 32'h1);
    cyc(400);
    chk(32'(afe.gain), 32'h2);
    apb(1'b1, REG_CFG, 32'h0006_1c01);
    apb(1'b1, REG_CFG, 32'h0006_5c01);
    level <= 2'h2;
    cyc(100);
    chk(32'(afe.gain), 32'h6);
    $display("gain control test done");
    close_out();
  end
  // A hang counts as a mismatch and ends the run the same way.
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule
